// >>> shared/fmrc_map.svh
// Purpose: constants of the flash mode and reset control block
// Assumes: single device, opcodes and table bytes fixed
// Notes:   included by the package and the top design file
//
// How it works
// - dual and quad io fast reads capture the eight mode bits
// - mode field one-zero makes the next frame the same read, no opcode
// - any other mode field value returns to normal command decoding
// - upper two and lower four mode bits are ignored
// - during continuous read no command but continuous read reset, reset pair included, is decoded
// - continuous read reset leaves continuous read and four-wire mode
// - host sets quad enable, then enable command switches to four-wire mode
// - enable command with quad enable low only clears a pending reset enable
// - mode switches keep write latch, suspend state and wrap length
// - four-wire mode ends on disable command or quad enable low
// - disable command also ends continuous read
// - no-operation only cancels a pending reset enable
// - no-operation ignores data lines one to three in single-wire mode
// - reset runs only directly after reset enable, sent back to back
// - any other command after reset enable clears the pending enable
// - software reset returns to standby with power-up defaults
// - software reset during program or erase aborts it
// - table bytes 65h:64h report reset opcode in bits 11 to 4
// - table byte 66h gives wrap opcode, 67h lengths 8 to 64

`ifndef FMRC_MAP_SVH
`define FMRC_MAP_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define FMRC_OP_CONT_RST  8'hff
`define FMRC_OP_QPI_EN    8'h38
`define FMRC_OP_NOP       8'h00
`define FMRC_OP_RST_EN    8'h66
`define FMRC_OP_RESET     8'h99
`define FMRC_OP_DUAL_RD   8'hbb
`define FMRC_OP_QUAD_RD   8'heb
`define FMRC_MODE_CONT    2'h2

// ----------------------------------------
// capture layout, in clock edges
// ----------------------------------------
`define FMRC_CAP_DEPTH    5'h18
`define FMRC_CNT_MAX      5'h1f
`define FMRC_OP_EDGES_S   5'h08
`define FMRC_OP_EDGES_Q   5'h02
`define FMRC_MD_CMD       5'h14
`define FMRC_MD_CONT      5'h0c
`define FMRC_MD_EDGES     5'h04
`define FMRC_MQ_SPI       5'h0e
`define FMRC_MQ_QPI       5'h08
`define FMRC_MQ_CONT      5'h06
`define FMRC_MQ_EDGES     5'h02

// ----------------------------------------
// discovery table bytes
// ----------------------------------------
`define FMRC_SFDP_A_RST_LO 8'h64
`define FMRC_SFDP_A_RST_HI 8'h65
`define FMRC_SFDP_A_WRAP   8'h66
`define FMRC_SFDP_A_WLEN   8'h67
`define FMRC_SFDP_RST_LO   8'h9e
`define FMRC_SFDP_RST_HI   8'hf9
`define FMRC_SFDP_WRAP     8'h77
`define FMRC_SFDP_WLEN     8'h64
`define FMRC_SFDP_OTHER    8'h00

`endif

// >>> shared/fmrc_pkg.sv
// Purpose: types of the flash mode and reset control block
// Assumes: fmrc_map.svh holds all numbers
// Notes:   core state and link state are separate structs

`include "fmrc_map.svh"

package fmrc_pkg;

    // ----------------------------------------
    // frame readout sequencer
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_DEC  = 2'b10
    } fmrc_state_e;

    // ----------------------------------------
    // core domain state
    // ----------------------------------------
    typedef struct packed {
        logic        cs_s1;
        logic        cs_s2;
        logic        cs_s3;
        logic        cs_hi;
        fmrc_state_e st;
        logic [4:0]  idx;
        logic [4:0]  didx;
        logic [4:0]  cnt;
        logic        dv;
        logic [7:0]  opc_s;
        logic [7:0]  opc_q;
        logic [7:0]  mode_d;
        logic [7:0]  mode_q;
        logic        four_wire_command_mode;
        logic        cont;
        logic        cont_quad;
        logic        arm;
        logic        sw_reset;
        logic        abort;
        logic        cmd_valid;
        logic [7:0]  cmd_code;
        logic [7:0]  sfdp;
    } fmrc_core_s;

    // ----------------------------------------
    // link domain state
    // ----------------------------------------
    typedef struct packed {
        logic        first;
        logic [4:0]  cnt;
    } fmrc_link_s;

endpackage

// >>> rtl/fmrc_cap_mem.sv
// Purpose: frame capture store, one nibble per link clock edge
// Assumes: written on the link clock, read on the core clock
// Notes:   read data registered; reader waits until frame end

module fmrc_cap_mem (
    input  logic       wr_clk,
    input  logic       wr_en,
    input  logic [4:0] wr_addr,
    input  logic [3:0] wr_data,
    input  logic       rd_clk,
    input  logic [4:0] rd_addr,
    output logic [3:0] rd_data
);
    logic [3:0] mem_q [0:23];

    // ----------------------------------------
    // write and registered read
    // ----------------------------------------
    always_ff @(posedge wr_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge rd_clk) begin
        rd_data <= mem_q[rd_addr];
    end
endmodule

// >>> rtl/fmrc_top.sv
// Purpose: command mode and software reset control of the serial flash
// Assumes: host drives spi_clk and cs_n; quad_enable and busy on core_clk
// Notes:   frames are decoded after chip select rises, from the capture store

`include "fmrc_map.svh"

module fmrc_top (
    input  logic       core_clk,
    input  logic       rst,
    input  logic       spi_clk,
    input  logic       cs_n,
    input  logic [3:0] io_in,
    input  logic       quad_enable,
    input  logic       busy,
    input  logic [7:0] sfdp_addr,
    output logic       qpi_mode,
    output logic       cont_read,
    output logic       cont_quad,
    output logic       reset_armed,
    output logic       sw_reset,
    output logic       op_abort,
    output logic       cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] sfdp_data
);
    import fmrc_pkg::*;

    fmrc_core_s c_q;
    fmrc_core_s c_d;
    fmrc_link_s lk_q;
    fmrc_link_s lk_d;
    logic [4:0] wr_addr;
    logic       wr_en;
    logic [3:0] rd_data;
    logic [4:0] md;
    logic [4:0] mq;
    logic [7:0] dec_op;
    logic       op_ok;
    logic       md_ok;
    logic       mq_ok;
    logic       dec_now;
    logic       frame_end;

    // ----------------------------------------
    // link side: edge counter and capture
    // ----------------------------------------
    always_comb begin
        lk_d = lk_q;
        lk_d.first = 1'b0;
        if (lk_q.first) begin
            lk_d.cnt = 5'h01;
        end else if (lk_q.cnt != `FMRC_CNT_MAX) begin
            lk_d.cnt = lk_q.cnt + 5'h01;
        end
    end

    // chip select high ends the frame; the count is kept for the core
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            lk_q.first <= 1'b1;
        end else begin
            lk_q <= lk_d;
        end
    end

    assign wr_addr = lk_q.first ? 5'h00 : lk_q.cnt;
    assign wr_en   = lk_q.first || (lk_q.cnt < `FMRC_CAP_DEPTH);

    fmrc_cap_mem u_cap (
        .wr_clk  (spi_clk),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (io_in),
        .rd_clk  (core_clk),
        .rd_addr (c_q.idx),
        .rd_data (rd_data)
    );

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // mode bit positions depend on whether an opcode was sent
    assign md = c_q.cont ? `FMRC_MD_CONT : `FMRC_MD_CMD;
    assign mq = c_q.cont ? `FMRC_MQ_CONT : (c_q.four_wire_command_mode ? `FMRC_MQ_QPI : `FMRC_MQ_SPI);
    assign dec_op = c_q.four_wire_command_mode ? c_q.opc_q : c_q.opc_s;
    assign op_ok  = c_q.cnt >= (c_q.four_wire_command_mode ? `FMRC_OP_EDGES_Q : `FMRC_OP_EDGES_S);
    assign md_ok  = c_q.cnt >= 5'(md + `FMRC_MD_EDGES);
    assign mq_ok  = c_q.cnt >= 5'(mq + `FMRC_MQ_EDGES);
    assign dec_now = (c_q.st == ST_DEC);
    assign frame_end = (c_q.cs_s2 == c_q.cs_s3) && c_q.cs_s3 && !c_q.cs_hi;

    // ----------------------------------------
    // core side next state
    // ----------------------------------------
    always_comb begin
        c_d = c_q;
        c_d.cs_s1 = cs_n;
        c_d.cs_s2 = c_q.cs_s1;
        c_d.cs_s3 = c_q.cs_s2;
        if (c_q.cs_s2 == c_q.cs_s3) begin
            c_d.cs_hi = c_q.cs_s3;
        end
        c_d.sw_reset  = 1'b0;
        c_d.abort     = 1'b0;
        c_d.cmd_valid = 1'b0;
        c_d.dv        = 1'b0;

        // discovery table bytes
        case (sfdp_addr)
            `FMRC_SFDP_A_RST_LO: c_d.sfdp = `FMRC_SFDP_RST_LO;
            `FMRC_SFDP_A_RST_HI: c_d.sfdp = `FMRC_SFDP_RST_HI;
            `FMRC_SFDP_A_WRAP:   c_d.sfdp = `FMRC_SFDP_WRAP;
            `FMRC_SFDP_A_WLEN:   c_d.sfdp = `FMRC_SFDP_WLEN;
            default:             c_d.sfdp = `FMRC_SFDP_OTHER;
        endcase

        // quad enable low drops four-wire mode
        if (!quad_enable) begin
            c_d.four_wire_command_mode = 1'b0;
        end

        // assemble opcode and mode bits from captured nibbles
        if (c_q.dv) begin
            if (c_q.didx < `FMRC_OP_EDGES_S) begin
                c_d.opc_s = {c_q.opc_s[6:0], rd_data[0]};
            end
            if (c_q.didx < `FMRC_OP_EDGES_Q) begin
                c_d.opc_q = {c_q.opc_q[3:0], rd_data};
            end
            if (c_q.didx >= md && c_q.didx < 5'(md + `FMRC_MD_EDGES)) begin
                c_d.mode_d = {c_q.mode_d[5:0], rd_data[1:0]};
            end
            if (c_q.didx >= mq && c_q.didx < 5'(mq + `FMRC_MQ_EDGES)) begin
                c_d.mode_q = {c_q.mode_q[3:0], rd_data};
            end
        end

        unique case (c_q.st)
            ST_IDLE: begin
                if (frame_end) begin
                    c_d.st     = ST_READ;
                    c_d.idx    = 5'h00;
                    c_d.opc_s  = 8'h00;
                    c_d.opc_q  = 8'h00;
                    c_d.mode_d = 8'h00;
                    c_d.mode_q = 8'h00;
                    c_d.cnt    = (lk_q.cnt > `FMRC_CAP_DEPTH) ? `FMRC_CAP_DEPTH : lk_q.cnt;
                end
            end
            ST_READ: begin
                if (c_q.idx == c_q.cnt) begin
                    c_d.st = ST_DEC;
                end else begin
                    c_d.dv   = 1'b1;
                    c_d.didx = c_q.idx;
                    c_d.idx  = c_q.idx + 5'h01;
                end
            end
            ST_DEC: begin
                c_d.st = ST_IDLE;
                if (c_q.cont) begin
                    // only continuous read reset is decoded while in continuous read
                    if (op_ok && dec_op == `FMRC_OP_CONT_RST) begin
                        c_d.cont = 1'b0;
                        c_d.four_wire_command_mode  = 1'b0;
                    end else begin
                        c_d.cmd_valid = 1'b1;
                        c_d.cmd_code  = c_q.cont_quad ? `FMRC_OP_QUAD_RD : `FMRC_OP_DUAL_RD;
                        if (c_q.cont_quad) begin
                            c_d.cont = mq_ok && c_q.mode_q[5:4] == `FMRC_MODE_CONT;
                        end else begin
                            c_d.cont = md_ok && c_q.mode_d[5:4] == `FMRC_MODE_CONT;
                        end
                    end
                end else if (op_ok) begin
                    c_d.arm = 1'b0;
                    case (dec_op)
                        `FMRC_OP_CONT_RST: begin
                            c_d.cont = 1'b0;
                            c_d.four_wire_command_mode  = 1'b0;
                        end
                        `FMRC_OP_QPI_EN: begin
                            // only the mode flag changes here
                            if (quad_enable) begin
                                c_d.four_wire_command_mode = 1'b1;
                            end
                        end
                        `FMRC_OP_NOP: begin
                            c_d.arm = 1'b0;
                        end
                        `FMRC_OP_RST_EN: begin
                            c_d.arm = 1'b1;
                        end
                        `FMRC_OP_RESET: begin
                            if (c_q.arm) begin
                                c_d.sw_reset  = 1'b1;
                                c_d.abort     = busy;
                                c_d.four_wire_command_mode       = 1'b0;
                                c_d.cont      = 1'b0;
                                c_d.cont_quad = 1'b0;
                            end
                        end
                        `FMRC_OP_DUAL_RD: begin
                            c_d.cmd_valid = 1'b1;
                            c_d.cmd_code  = dec_op;
                            if (!c_q.four_wire_command_mode) begin
                                c_d.cont_quad = 1'b0;
                                c_d.cont = md_ok && c_q.mode_d[5:4] == `FMRC_MODE_CONT;
                            end
                        end
                        `FMRC_OP_QUAD_RD: begin
                            c_d.cmd_valid = 1'b1;
                            c_d.cmd_code  = dec_op;
                            c_d.cont_quad = 1'b1;
                            c_d.cont = mq_ok && c_q.mode_q[5:4] == `FMRC_MODE_CONT;
                        end
                        default: begin
                            c_d.cmd_valid = 1'b1;
                            c_d.cmd_code  = dec_op;
                        end
                    endcase
                end
            end
            default: begin
                c_d.st = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // core registers and outputs
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            c_q       <= '0;
            // chip select idles high, so no false frame end after reset
            c_q.cs_s1 <= 1'b1;
            c_q.cs_s2 <= 1'b1;
            c_q.cs_s3 <= 1'b1;
            c_q.cs_hi <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end

    assign qpi_mode      = c_q.four_wire_command_mode;
    assign cont_read     = c_q.cont;
    assign cont_quad     = c_q.cont_quad;
    assign reset_armed   = c_q.arm;
    assign sw_reset      = c_q.sw_reset;
    assign op_abort      = c_q.abort;
    assign cmd_valid     = c_q.cmd_valid;
    assign cmd_code      = c_q.cmd_code;
    assign sfdp_data     = c_q.sfdp;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_dec_op(logic [7:0] op);
        dec_now && !c_q.cont && op_ok && dec_op == op;
    endsequence

    sequence s_dec_cont;
        dec_now && c_q.cont;
    endsequence

    a_qe_low_drop: assert property (!quad_enable |=> !qpi_mode)
        else $error("four-wire mode held with quad enable low");

    a_qpi_en_ignored: assert property (
        s_dec_op(`FMRC_OP_QPI_EN) and (!quad_enable && !qpi_mode) |=> !qpi_mode)
        else $error("enable accepted without quad enable");

    a_qpi_en_taken: assert property (
        s_dec_op(`FMRC_OP_QPI_EN) and quad_enable |=> qpi_mode)
        else $error("enable with quad enable not taken");

    sequence s_cont_go;
        dec_now && c_q.cont && !(op_ok && dec_op == `FMRC_OP_CONT_RST);
    endsequence

    a_reset_needs_en: assert property (sw_reset |-> $past(reset_armed))
        else $error("software reset without reset enable");

    a_arm_cleared: assert property (
        dec_now && !c_q.cont && op_ok && dec_op != `FMRC_OP_RST_EN |=> !reset_armed)
        else $error("reset enable survives another command");

    a_arm_set: assert property (s_dec_op(`FMRC_OP_RST_EN) |=> reset_armed)
        else $error("reset enable not armed");

    a_reset_defaults: assert property (
        sw_reset |-> !qpi_mode && !cont_read && !reset_armed)
        else $error("software reset left mode state set");

    a_abort_on_busy: assert property (
        s_dec_op(`FMRC_OP_RESET) and (reset_armed && busy) |=> sw_reset && op_abort)
        else $error("reset during busy did not abort");

    a_cont_rst_exit: assert property (
        s_dec_op(`FMRC_OP_CONT_RST) |=> !cont_read && !qpi_mode)
        else $error("continuous read reset did not exit");

    a_cont_rst_qpi: assert property (
        s_dec_cont and (op_ok && dec_op == `FMRC_OP_CONT_RST) |=> !cont_read && !qpi_mode)
        else $error("continuous read kept after exit command");

    a_cont_no_decode: assert property (
        s_cont_go |=> cmd_valid && !sw_reset && $stable(reset_armed))
        else $error("command decoded during continuous read");

    a_dual_stay: assert property (
        s_cont_go and (!c_q.cont_quad && md_ok && c_q.mode_d[5:4] == `FMRC_MODE_CONT)
        |=> cont_read && cmd_code == `FMRC_OP_DUAL_RD)
        else $error("dual continuous read not kept");

    a_dual_leave: assert property (
        s_cont_go and (!c_q.cont_quad && !(md_ok && c_q.mode_d[5:4] == `FMRC_MODE_CONT))
        |=> !cont_read)
        else $error("dual continuous read not left");

    a_quad_stay: assert property (
        s_cont_go and (c_q.cont_quad && mq_ok && c_q.mode_q[5:4] == `FMRC_MODE_CONT)
        |=> cont_read && cmd_code == `FMRC_OP_QUAD_RD)
        else $error("quad continuous read not kept");

    a_quad_leave: assert property (
        s_cont_go and (c_q.cont_quad && !(mq_ok && c_q.mode_q[5:4] == `FMRC_MODE_CONT))
        |=> !cont_read)
        else $error("quad continuous read not left");

    a_nop_only: assert property (
        s_dec_op(`FMRC_OP_NOP) and quad_enable |=> !reset_armed && $stable(qpi_mode)
        && $stable(cont_read) && !cmd_valid)
        else $error("no-operation changed other state");

    a_sfdp_reset_hi: assert property (
        sfdp_addr == `FMRC_SFDP_A_RST_HI |=> sfdp_data == `FMRC_SFDP_RST_HI)
        else $error("table reset opcode high byte wrong");

    a_sfdp_wrap_op: assert property (
        sfdp_addr == `FMRC_SFDP_A_WRAP |=> sfdp_data == `FMRC_SFDP_WRAP)
        else $error("table wrap opcode byte wrong");

    a_sfdp_reset_op: assert property (
        sfdp_addr == `FMRC_SFDP_A_RST_LO |=> sfdp_data == `FMRC_SFDP_RST_LO)
        else $error("table reset opcode byte wrong");

    a_sfdp_wrap_len: assert property (
        sfdp_addr == `FMRC_SFDP_A_WLEN |=> sfdp_data == `FMRC_SFDP_WLEN)
        else $error("table wrap length byte wrong");

    a_frame_decode: assert property (
        frame_end && c_q.st == ST_IDLE |-> ##[1:27] dec_now)
        else $error("frame not decoded in time");
endmodule

// >>> dv/fmrc_host_model.sv
// Purpose: spi host model driving the link of the mode and reset control
// Assumes: a frame is up to 24 nibbles, first edge in the top nibble
// Notes:   link clock stands still between frames; released lines show inverse

module fmrc_host_model (
    output logic       spi_clk,
    output logic       cs_n,
    output logic [3:0] io_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        spi_clk = 1'b0;
        cs_n    = 1'b0;
        io_in   = 4'h0;
        // a rising chip select primes the link edge flag
        #1 cs_n = 1'b1;
    end

    // ----------------------------------------
    // one frame, 15 ns link clock
    // ----------------------------------------
    task automatic frame(input logic [95:0] nib, input int n);
        logic [3:0] last;
        last = 4'h0;
        cs_n = 1'b0;
        #20;
        for (int i = 0; i < n; i++) begin
            last  = nib[95-4*i -: 4];
            io_in = last;
            #7.5 spi_clk = 1'b1;
            #7.5 spi_clk = 1'b0;
        end
        #20 cs_n = 1'b1;
        io_in = ~last;
    endtask
endmodule

// >>> dv/tb.sv
// Purpose: self-checking bench of the flash mode and reset control
// Assumes: design latency per frame below 45 core cycles
// Notes:   one-cycle pulses are counted at the falling edge

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fmrc_pkg::*;

    logic        core_clk;
    logic        rst;
    logic        spi_clk;
    logic        cs_n;
    logic [3:0]  io_in;
    logic        quad_enable;
    logic        busy;
    logic [7:0]  sfdp_addr;
    logic        qpi_mode;
    logic        cont_read;
    logic        cont_quad;
    logic        reset_armed;
    logic        sw_reset;
    logic        op_abort;
    logic        cmd_valid;
    logic [7:0]  cmd_code;
    logic [7:0]  sfdp_data;
    logic [7:0]  rst_seen = 8'h00;
    logic [7:0]  abort_seen = 8'h00;
    logic [7:0]  cv_seen = 8'h00;
    logic [7:0]  cv_mark;
    logic [95:0] v;
    logic [7:0]  tbl [6];
    int          err_total;
    int          total_checks;

    fmrc_top dut_u (
        .core_clk(core_clk), .rst(rst), .spi_clk(spi_clk), .cs_n(cs_n), .io_in(io_in),
        .quad_enable(quad_enable), .busy(busy), .sfdp_addr(sfdp_addr),
        .qpi_mode(qpi_mode), .cont_read(cont_read), .cont_quad(cont_quad),
        .reset_armed(reset_armed), .sw_reset(sw_reset), .op_abort(op_abort),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .sfdp_data(sfdp_data)
    );

    fmrc_host_model host_u (.spi_clk(spi_clk), .cs_n(cs_n), .io_in(io_in));

    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;

    always @(negedge core_clk) begin
        if (sw_reset === 1'b1) rst_seen++;
        if (op_abort === 1'b1) abort_seen++;
        if (cmd_valid === 1'b1) cv_seen++;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [95:0] spi_op(input logic [7:0] b, input logic [2:0] up);
        logic [95:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) r[95-4*i -: 4] = {up, b[7-i]};
        return r;
    endfunction

    function automatic logic [95:0] dual_mode(input logic [95:0] r, input logic [7:0] m);
        for (int k = 0; k < 4; k++) r[15-4*k -: 4] = {2'b00, m[7-2*k -: 2]};
        return r;
    endfunction

    function automatic logic [7:0] st();
        return {4'h0, qpi_mode, cont_read, cont_quad, reset_armed};
    endfunction

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic send(input logic [95:0] nib, input int n);
        host_u.frame(nib, n);
        repeat (45) @(negedge core_clk);
    endtask

    task automatic spi(input logic [7:0] b);
        send(spi_op(b, 3'b000), 8);
    endtask

    task automatic four_wire_command_mode(input logic [7:0] b);
        send({b, 88'h0}, 2);
    endtask

    task automatic conclude;
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge core_clk);
        err_total++;
        conclude();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        tbl = '{8'h00, 8'h9e, 8'hf9, 8'h77, 8'h64, 8'h00};
        rst = 1'b1;
        quad_enable = 1'b0;
        busy = 1'b0;
        sfdp_addr = 8'h00;
        err_total = 0;
        total_checks = 0;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        repeat (8) @(negedge core_clk);
        chk("state", st(), 8'h00);
        for (int a = 0; a < 6; a++) begin
            sfdp_addr = 8'h63 + a[7:0];
            @(negedge core_clk);
            chk("sfdp", sfdp_data, tbl[a]);
        end
        spi(8'hff);
        spi(8'h66);
        chk("state", st(), 8'h01);
        send(spi_op(8'h00, 3'b111), 8);
        chk("state", st(), 8'h00);
        spi(8'h66);
        spi(8'h99);
        chk("resets", rst_seen, 8'h01);
        chk("aborts", abort_seen, 8'h00);
        spi(8'h66);
        spi(8'h38);
        chk("state", st(), 8'h00);
        spi(8'h99);
        chk("resets", rst_seen, 8'h01);
        quad_enable = 1'b1;
        spi(8'h38);
        chk("state", st(), 8'h08);
        send({8'heb, 24'h123456, 8'hef, 56'h0}, 10);
        chk("state", st(), 8'h0e);
        chk("code", cmd_code, 8'heb);
        four_wire_command_mode(8'hff);
        chk("state", st(), 8'h02);
        spi(8'h38);
        quad_enable = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("state", st(), 8'h02);
        quad_enable = 1'b1;
        v = spi_op(8'heb, 3'b000);
        v[63:40] = 24'h123456;
        v[39:32] = 8'h20;
        send(v, 16);
        chk("state", st(), 8'h06);
        cv_mark = cv_seen;
        send({24'h654321, 8'h6a, 64'h0}, 8);
        chk("state", st(), 8'h06);
        chk("frames", cv_seen - cv_mark, 8'h01);
        chk("code", cmd_code, 8'heb);
        send({24'h654321, 8'h30, 64'h0}, 8);
        chk("state", st(), 8'h02);
        send(dual_mode(spi_op(8'hbb, 3'b000), 8'h20), 24);
        chk("state", st(), 8'h04);
        chk("code", cmd_code, 8'hbb);
        send({96{1'b1}}, 8);
        chk("state", st(), 8'h00);
        spi(8'h38);
        busy = 1'b1;
        four_wire_command_mode(8'h66);
        four_wire_command_mode(8'h99);
        chk("resets", rst_seen, 8'h02);
        chk("aborts", abort_seen, 8'h01);
        chk("state", st(), 8'h00);
        busy = 1'b0;
        conclude();
    end
endmodule
